// File: mrpg_pkg.sv
// constants and types shared by the mission register and password gate block
package mrpg_pkg;
  localparam int ADDR_W = 16;
  localparam logic [15:0] OFS_DELAY = 16'h0216;
  localparam logic [15:0] OFS_DELAY_END = 16'h0218;
  localparam logic [15:0] OFS_STAMP = 16'h0219;
  localparam logic [15:0] OFS_STAMP_END = 16'h021E;
  localparam logic [15:0] OFS_MCOUNT = 16'h0220;
  localparam logic [15:0] OFS_MCOUNT_END = 16'h0222;
  localparam logic [15:0] OFS_LCOUNT = 16'h0223;
  localparam logic [15:0] OFS_LCOUNT_END = 16'h0225;
  localparam logic [15:0] OFS_PART = 16'h0226;
  localparam logic [15:0] OFS_PWCTL = 16'h0227;
  localparam logic [15:0] OFS_RPW = 16'h0228;
  localparam logic [15:0] OFS_FPW = 16'h0230;
  localparam logic [15:0] OFS_PW_END = 16'h0237;
  localparam int PW_PAGE_BYTES = 17;
  localparam int PW_BYTES = 8;
  localparam int STAMP_W = 48;
  localparam int CNT_W = 24;
  localparam int PW_W = 64;
  localparam logic [5:0] PW_LAST_BIT = 6'h3F;
  localparam logic [7:0] PW_ENABLE_PATTERN = 8'hAA;
  localparam logic [7:0] PWCTL_RESET = 8'h00;
  // part variant code: value is arbitrary
  localparam logic [7:0] PART_CODE = 8'h5C;
  localparam logic [23:0] CNT_MAX = 24'hFF_FFFF;
  localparam logic [23:0] DELAY_RESET = 24'h00_0000;
  localparam logic [16:0] PW_MASK_FULL = 17'h1_FFFF;

  typedef enum logic [2:0] {
    CMD_CHECKED_READ,
    CMD_COMMIT,
    CMD_WIPE,
    CMD_START,
    CMD_STOP,
    CMD_MEASURE
  } mrpg_cmd_t;

  typedef enum logic [2:0] {
    MS_IDLE,
    MS_DELAY,
    MS_WAIT_ALARM,
    MS_STAMP_WAIT,
    MS_LOGGING
  } mrpg_state_t;
endpackage

// File: mrpg_top.sv
// mission bookkeeping registers and password gating of commands
`timescale 1ns/10ps

// Behaviour
// - Wait the programmed minutes after start before first sample or alarm testing.
// - Start delay is a 24-bit minute count, low byte at the first address.
// - In start-on-alarm mode the whole delay expires before alarm testing.
// - Start-delay bytes are readable always, writes refused during a mission.
// - Six read-only BCD bytes hold the time of the first mission sample; with start-on-alarm, of the sample after the alarm-triggered one.
// - Read-only 24-bit mission count rises on each mission log wake except the alarm-triggered first log; alarm-test wakes do not count.
// - The record wipe command zeroes the mission count.
// - Lifetime count rises on mission log wakes and on alarm-test wakes.
// - Outside a mission, each manual measure command raises the lifetime count.
// - Lifetime count is 24-bit unsigned, topping out at 16,777,215.
// - A read-only byte holds a fixed part variant code.
// - Manual measure needs no password; staging buffer writes need an open commit window.
// - Checking is on only when the control byte is 10101010; default differs.
// - With checking off, any 64-bit password is accepted.
// - With checking on, password or control changes need the full password.
// - Password bytes are write-only and read back as zero.
// - Passwords cannot change while a mission is running.
// - Read password, bit 0 first, unlocks only the checked memory read.
// - Checked read takes either password; commit, wipe, start, stop need full password or checking off.
// - Start-on-alarm chooses immediate or delayed logging versus alarm-triggered logging.
// - Mission-active flag is set while a mission runs and cleared at its end.
module mrpg_top (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CMD_VALID,
  input wire logic [2:0] CMD_CODE,
  input wire logic PW_BIT_VALID,
  input wire logic PW_BIT,
  input wire logic [15:0] MEM_ADDR,
  input wire logic MEM_RD,
  input wire logic MEM_WR,
  input wire logic [7:0] MEM_WDATA,
  input wire logic COMMIT_END,
  input wire logic START_ON_ALARM,
  input wire logic MINUTE_TICK,
  input wire logic SAMPLE_TICK,
  input wire logic ALARM_HIT,
  input wire logic [47:0] RTC_TIME,
  output logic [7:0] MEM_RDATA,
  output logic MEM_RVALID,
  output logic CMD_DONE,
  output logic CMD_OK,
  output logic COMMIT_OPEN,
  output logic MISSION_ACTIVE,
  output logic WAITING_ALARM,
  output logic WAKE_MEASURE,
  output logic LOG_SAMPLE
);
  // command and password collection
  logic collecting_q;
  logic [5:0] bit_cnt_q;
  logic [63:0] pw_shift_q;
  mrpg_pkg::mrpg_cmd_t pend_cmd_q;
  logic exec_q;
  // registers
  logic [23:0] start_delay_q;
  logic [47:0] stamp_q;
  logic [23:0] mission_cnt_q;
  logic [23:0] life_cnt_q;
  logic [7:0] pw_ctl_q;
  logic [63:0] read_pw_q;
  logic [63:0] full_pw_q;
  logic [7:0] pw_stage_q [mrpg_pkg::PW_PAGE_BYTES];
  logic [16:0] pw_mask_q;
  // mission sequencing
  mrpg_pkg::mrpg_state_t state_q;
  logic [23:0] delay_cnt_q;
  logic start_on_alarm_q;

  logic check_on, full_ok, read_ok, grant, measure_cmd;
  logic mission_sample, alarm_test, first_alarm_log, stamp_now, life_inc;
  logic [15:0] rel;
  logic [7:0] rd_byte;

  assign check_on = (pw_ctl_q == mrpg_pkg::PW_ENABLE_PATTERN);
  assign full_ok = !check_on || (pw_shift_q == full_pw_q);
  assign read_ok = full_ok || (pw_shift_q == read_pw_q);
  assign measure_cmd = CMD_VALID && (CMD_CODE == mrpg_pkg::CMD_MEASURE);

  // a denied command changes nothing because every effect keys off grant
  always_comb begin
    grant = 1'b0;
    if (exec_q) begin
      unique case (pend_cmd_q)
        mrpg_pkg::CMD_CHECKED_READ: grant = read_ok;
        mrpg_pkg::CMD_COMMIT: grant = full_ok;
        mrpg_pkg::CMD_WIPE: grant = full_ok && !MISSION_ACTIVE;
        mrpg_pkg::CMD_START: grant = full_ok && !MISSION_ACTIVE;
        mrpg_pkg::CMD_STOP: grant = full_ok && MISSION_ACTIVE;
        default: grant = 1'b0;
      endcase
    end
  end

  // password bits arrive bit 0 first and end up in bit 0 of the shifter
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      collecting_q <= 1'b0;
      bit_cnt_q <= 6'h00;
      pw_shift_q <= 64'h0000_0000_0000_0000;
      pend_cmd_q <= mrpg_pkg::CMD_CHECKED_READ;
      exec_q <= 1'b0;
    end else begin
      exec_q <= 1'b0;
      if (CMD_VALID) begin
        collecting_q <= (CMD_CODE <= 3'(mrpg_pkg::CMD_STOP));
        bit_cnt_q <= 6'h00;
        pend_cmd_q <= mrpg_pkg::mrpg_cmd_t'(CMD_CODE);
      end else if (collecting_q && PW_BIT_VALID) begin
        pw_shift_q <= {PW_BIT, pw_shift_q[63:1]};
        bit_cnt_q <= bit_cnt_q + 6'h01;
        if (bit_cnt_q == mrpg_pkg::PW_LAST_BIT) begin
          collecting_q <= 1'b0;
          exec_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      CMD_DONE <= 1'b0;
      CMD_OK <= 1'b0;
    end else begin
      CMD_DONE <= exec_q || measure_cmd;
      if (exec_q || measure_cmd) begin
        CMD_OK <= grant || (measure_cmd && !MISSION_ACTIVE);
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      COMMIT_OPEN <= 1'b0;
    end else if (grant && pend_cmd_q == mrpg_pkg::CMD_COMMIT) begin
      COMMIT_OPEN <= 1'b1;
    end else if (COMMIT_END) begin
      COMMIT_OPEN <= 1'b0;
    end
  end

  assign rel = MEM_ADDR - mrpg_pkg::OFS_PWCTL;

  // start delay is written directly by the commit, refused during a mission
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      start_delay_q <= mrpg_pkg::DELAY_RESET;
    end else if (COMMIT_OPEN && MEM_WR && !MISSION_ACTIVE) begin
      if (MEM_ADDR == mrpg_pkg::OFS_DELAY) begin
        start_delay_q[7:0] <= MEM_WDATA;
      end else if (MEM_ADDR == mrpg_pkg::OFS_DELAY + 16'h0001) begin
        start_delay_q[15:8] <= MEM_WDATA;
      end else if (MEM_ADDR == mrpg_pkg::OFS_DELAY_END) begin
        start_delay_q[23:16] <= MEM_WDATA;
      end
    end
  end

  // control byte and passwords are staged and only take effect as a whole page
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pw_ctl_q <= mrpg_pkg::PWCTL_RESET;
      read_pw_q <= 64'h0000_0000_0000_0000;
      full_pw_q <= 64'h0000_0000_0000_0000;
      pw_mask_q <= 17'h0_0000;
      for (int i = 0; i < mrpg_pkg::PW_PAGE_BYTES; i++) begin
        pw_stage_q[i] <= 8'h00;
      end
    end else begin
      if (grant && pend_cmd_q == mrpg_pkg::CMD_COMMIT) begin
        pw_mask_q <= 17'h0_0000;
      end else if (COMMIT_OPEN && COMMIT_END) begin
        if (pw_mask_q == mrpg_pkg::PW_MASK_FULL && !MISSION_ACTIVE) begin
          pw_ctl_q <= pw_stage_q[0];
          for (int i = 0; i < mrpg_pkg::PW_BYTES; i++) begin
            read_pw_q[8*i +: 8] <= pw_stage_q[1 + i];
            full_pw_q[8*i +: 8] <= pw_stage_q[1 + mrpg_pkg::PW_BYTES + i];
          end
        end
        pw_mask_q <= 17'h0_0000;
      end else if (COMMIT_OPEN && MEM_WR && MEM_ADDR >= mrpg_pkg::OFS_PWCTL
                   && MEM_ADDR <= mrpg_pkg::OFS_PW_END) begin
        pw_stage_q[rel[4:0]] <= MEM_WDATA;
        pw_mask_q[rel[4:0]] <= 1'b1;
      end
    end
  end

  // wake classification for the current cycle
  always_comb begin
    alarm_test = 1'b0;
    first_alarm_log = 1'b0;
    stamp_now = 1'b0;
    mission_sample = 1'b0;
    unique case (state_q)
      mrpg_pkg::MS_IDLE: ;
      mrpg_pkg::MS_DELAY: begin
        if (delay_cnt_q == mrpg_pkg::DELAY_RESET && !start_on_alarm_q) begin
          stamp_now = 1'b1;
          mission_sample = 1'b1;
        end
      end
      mrpg_pkg::MS_WAIT_ALARM: begin
        alarm_test = SAMPLE_TICK;
        first_alarm_log = SAMPLE_TICK && ALARM_HIT;
      end
      mrpg_pkg::MS_STAMP_WAIT: begin
        stamp_now = SAMPLE_TICK;
        mission_sample = SAMPLE_TICK;
      end
      mrpg_pkg::MS_LOGGING: mission_sample = SAMPLE_TICK;
    endcase
    life_inc = mission_sample || alarm_test || (measure_cmd && !MISSION_ACTIVE);
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_q <= mrpg_pkg::MS_IDLE;
      delay_cnt_q <= mrpg_pkg::DELAY_RESET;
      start_on_alarm_q <= 1'b0;
      MISSION_ACTIVE <= 1'b0;
      WAITING_ALARM <= 1'b0;
    end else if (grant && pend_cmd_q == mrpg_pkg::CMD_START) begin
      state_q <= mrpg_pkg::MS_DELAY;
      delay_cnt_q <= start_delay_q;
      start_on_alarm_q <= START_ON_ALARM;
      MISSION_ACTIVE <= 1'b1;
      WAITING_ALARM <= START_ON_ALARM;
    end else if (grant && pend_cmd_q == mrpg_pkg::CMD_STOP) begin
      state_q <= mrpg_pkg::MS_IDLE;
      MISSION_ACTIVE <= 1'b0;
    end else begin
      unique case (state_q)
        mrpg_pkg::MS_IDLE: ;
        mrpg_pkg::MS_DELAY: begin
          if (delay_cnt_q == mrpg_pkg::DELAY_RESET) begin
            state_q <= start_on_alarm_q ? mrpg_pkg::MS_WAIT_ALARM : mrpg_pkg::MS_LOGGING;
          end else if (MINUTE_TICK) begin
            delay_cnt_q <= delay_cnt_q - 24'h00_0001;
          end
        end
        mrpg_pkg::MS_WAIT_ALARM: begin
          if (first_alarm_log) begin
            state_q <= mrpg_pkg::MS_STAMP_WAIT;
            WAITING_ALARM <= 1'b0;
          end
        end
        mrpg_pkg::MS_STAMP_WAIT: begin
          if (SAMPLE_TICK) begin
            state_q <= mrpg_pkg::MS_LOGGING;
          end
        end
        mrpg_pkg::MS_LOGGING: ;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      WAKE_MEASURE <= 1'b0;
      LOG_SAMPLE <= 1'b0;
    end else begin
      WAKE_MEASURE <= life_inc;
      LOG_SAMPLE <= mission_sample || first_alarm_log;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      stamp_q <= 48'h0000_0000_0000;
      mission_cnt_q <= 24'h00_0000;
    end else if (grant && pend_cmd_q == mrpg_pkg::CMD_WIPE) begin
      stamp_q <= 48'h0000_0000_0000;
      mission_cnt_q <= 24'h00_0000;
    end else begin
      if (stamp_now) begin
        stamp_q <= RTC_TIME;
      end
      if (mission_sample) begin
        mission_cnt_q <= mission_cnt_q + 24'h00_0001;
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      life_cnt_q <= 24'h00_0000;
    end else if (life_inc && life_cnt_q != mrpg_pkg::CNT_MAX) begin
      life_cnt_q <= life_cnt_q + 24'h00_0001;
    end
  end

  // read map; password bytes and holes read zero
  always_comb begin
    logic [15:0] off;
    off = 16'h0000;
    rd_byte = 8'h00;
    if (MEM_ADDR >= mrpg_pkg::OFS_DELAY && MEM_ADDR <= mrpg_pkg::OFS_DELAY_END) begin
      off = MEM_ADDR - mrpg_pkg::OFS_DELAY;
      rd_byte = start_delay_q[{off[1:0], 3'b000} +: 8];
    end else if (MEM_ADDR >= mrpg_pkg::OFS_STAMP && MEM_ADDR <= mrpg_pkg::OFS_STAMP_END) begin
      off = MEM_ADDR - mrpg_pkg::OFS_STAMP;
      rd_byte = stamp_q[{off[2:0], 3'b000} +: 8];
    end else if (MEM_ADDR >= mrpg_pkg::OFS_MCOUNT && MEM_ADDR <= mrpg_pkg::OFS_MCOUNT_END) begin
      off = MEM_ADDR - mrpg_pkg::OFS_MCOUNT;
      rd_byte = mission_cnt_q[{off[1:0], 3'b000} +: 8];
    end else if (MEM_ADDR >= mrpg_pkg::OFS_LCOUNT && MEM_ADDR <= mrpg_pkg::OFS_LCOUNT_END) begin
      off = MEM_ADDR - mrpg_pkg::OFS_LCOUNT;
      rd_byte = life_cnt_q[{off[1:0], 3'b000} +: 8];
    end else if (MEM_ADDR == mrpg_pkg::OFS_PART) begin
      rd_byte = mrpg_pkg::PART_CODE;
    end else if (MEM_ADDR == mrpg_pkg::OFS_PWCTL) begin
      rd_byte = pw_ctl_q;
    end else begin
      rd_byte = 8'h00;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      MEM_RDATA <= 8'h00;
      MEM_RVALID <= 1'b0;
    end else begin
      MEM_RVALID <= MEM_RD;
      if (MEM_RD) begin
        MEM_RDATA <= rd_byte;
      end
    end
  end
endmodule

// File: mrpg_top_monitor.sv
// checker of the mission register and password gate ports
`timescale 1ns/10ps
module mrpg_top_monitor (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CMD_VALID,
  input wire logic [2:0] CMD_CODE,
  input wire logic [15:0] MEM_ADDR,
  input wire logic MEM_RD,
  input wire logic COMMIT_END,
  input wire logic [7:0] MEM_RDATA,
  input wire logic CMD_DONE,
  input wire logic CMD_OK,
  input wire logic COMMIT_OPEN,
  input wire logic MISSION_ACTIVE,
  input wire logic WAKE_MEASURE,
  input wire logic LOG_SAMPLE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  sequence measure_req(logic busy);
    CMD_VALID && CMD_CODE == 3'h5 && MISSION_ACTIVE == busy;
  endsequence
  sequence granted;
    CMD_DONE && CMD_OK;
  endsequence
  pw_zero_a: assert property (
    MEM_RD && MEM_ADDR >= mrpg_pkg::OFS_RPW && MEM_ADDR <= mrpg_pkg::OFS_PW_END
    |=> MEM_RDATA == 8'h00) else $error("password byte read nonzero");
  part_code_a: assert property (
    MEM_RD && MEM_ADDR == mrpg_pkg::OFS_PART |=> MEM_RDATA == mrpg_pkg::PART_CODE)
    else $error("part code wrong");
  measure_idle_a: assert property (
    measure_req(1'b0) |=> granted) else $error("idle measure not granted");
  measure_busy_a: assert property (
    measure_req(1'b1) |=> CMD_DONE && !CMD_OK) else $error("measure in mission granted");
  mission_rise_a: assert property (
    $rose(MISSION_ACTIVE) |-> granted) else $error("mission began without grant");
  refuse_keeps_a: assert property (
    CMD_DONE && !CMD_OK |-> $stable(MISSION_ACTIVE)) else $error("refusal changed mission");
  commit_rise_a: assert property (
    $rose(COMMIT_OPEN) |-> granted) else $error("commit opened without grant");
  commit_close_a: assert property (
    COMMIT_OPEN && COMMIT_END |=> !COMMIT_OPEN) else $error("commit window stayed open");
  log_in_mission_a: assert property (
    LOG_SAMPLE |-> $past(MISSION_ACTIVE)) else $error("sample logged outside mission");
  measure_wake_a: assert property (
    measure_req(1'b0) |=> WAKE_MEASURE) else $error("idle measure not counted");
endmodule
bind mrpg_top mrpg_top_monitor mrpg_top_monitor_inst (
  .CLK(CLK), .NRST(NRST), .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE),
  .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .COMMIT_END(COMMIT_END), .MEM_RDATA(MEM_RDATA),
  .CMD_DONE(CMD_DONE), .CMD_OK(CMD_OK), .COMMIT_OPEN(COMMIT_OPEN),
  .MISSION_ACTIVE(MISSION_ACTIVE), .WAKE_MEASURE(WAKE_MEASURE), .LOG_SAMPLE(LOG_SAMPLE)
);

// File: mrpg_host.sv
// host model that sends a command code followed by its 64-bit password, with no password after the measure code (3'h5)
`timescale 1ns/10ps
module mrpg_host (
  input wire logic clk,
  output logic cmd_valid,
  output logic [2:0] cmd_code,
  output logic pw_bit_valid,
  output logic pw_bit
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 3'h0;
    pw_bit_valid = 1'b0;
    pw_bit = 1'b0;
  end
  // changes land on the falling edge so each strobe is whole at the rising edge
  task automatic send(input logic [2:0] code, input logic [63:0] pw);
    @(negedge clk);
    cmd_code = code;
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_code = ~code;
    if (code != 3'h5) begin
      for (int i = 0; i < 64; i++) begin
        pw_bit = pw[i];
        pw_bit_valid = 1'b1;
        @(negedge clk);
      end
    end
    pw_bit_valid = 1'b0;
    pw_bit = ~pw_bit;
  endtask
endmodule

// File: testbench.sv
// self-checking bench for the mission register and password gate
`timescale 1ns/10ps
module testbench;
  logic CLK = 0, NRST = 0, MEM_RD = 0, MEM_WR = 0, COMMIT_END = 0, START_ON_ALARM = 0;
  logic MINUTE_TICK = 0, SAMPLE_TICK = 0, ALARM_HIT = 0;
  logic CMD_VALID, PW_BIT_VALID, PW_BIT, MEM_RVALID, CMD_DONE, CMD_OK, COMMIT_OPEN;
  logic MISSION_ACTIVE, WAITING_ALARM, WAKE_MEASURE, LOG_SAMPLE;
  logic [2:0] CMD_CODE;
  logic [15:0] MEM_ADDR = 16'h0000;
  logic [7:0] MEM_WDATA = 8'h00, MEM_RDATA;
  logic [47:0] RTC_TIME = 48'h0000_0000_0000;
  logic [63:0] rpw, fpw;
  logic [23:0] d, lt = 24'h00_0000;
  int failures = 0, n_tests = 0;
  always #50 CLK = ~CLK;
  mrpg_host mrpg_host_inst (.clk(CLK), .cmd_valid(CMD_VALID), .cmd_code(CMD_CODE),
    .pw_bit_valid(PW_BIT_VALID), .pw_bit(PW_BIT));
  mrpg_top mrpg_top_inst (.CLK(CLK), .NRST(NRST), .CMD_VALID(CMD_VALID),
    .CMD_CODE(CMD_CODE), .PW_BIT_VALID(PW_BIT_VALID), .PW_BIT(PW_BIT),
    .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_WDATA(MEM_WDATA),
    .COMMIT_END(COMMIT_END), .START_ON_ALARM(START_ON_ALARM), .MINUTE_TICK(MINUTE_TICK),
    .SAMPLE_TICK(SAMPLE_TICK), .ALARM_HIT(ALARM_HIT), .RTC_TIME(RTC_TIME),
    .MEM_RDATA(MEM_RDATA), .MEM_RVALID(MEM_RVALID), .CMD_DONE(CMD_DONE), .CMD_OK(CMD_OK),
    .COMMIT_OPEN(COMMIT_OPEN), .MISSION_ACTIVE(MISSION_ACTIVE),
    .WAITING_ALARM(WAITING_ALARM), .WAKE_MEASURE(WAKE_MEASURE), .LOG_SAMPLE(LOG_SAMPLE));
  function automatic logic gate(input logic [63:0] sent, input logic [63:0] key,
                                input logic on);
    return !on || sent === key;
  endfunction
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // multi-byte fields come back low byte first
  task automatic rd(input logic [15:0] a, input int n, output logic [47:0] v);
    v = 48'h0;
    for (int i = 0; i < n; i++) begin
      @(negedge CLK);
      MEM_ADDR = a + 16'(i);
      MEM_RD = 1'b1;
      @(negedge CLK);
      MEM_RD = 1'b0;
      chk("read valid", 48'h1, 48'(MEM_RVALID));
      v[8*i +: 8] = MEM_RDATA;
    end
  endtask
  task automatic wr(input logic [15:0] a, input int n, input logic [135:0] v);
    for (int i = 0; i < n; i++) begin
      @(negedge CLK);
      MEM_ADDR = a + 16'(i);
      MEM_WDATA = v[8*i +: 8];
      MEM_WR = 1'b1;
    end
    @(negedge CLK);
    MEM_WR = 1'b0;
    MEM_WDATA = ~MEM_WDATA;
  endtask
  task automatic close_commit();
    @(negedge CLK);
    COMMIT_END = 1'b1;
    @(negedge CLK);
    COMMIT_END = 1'b0;
  endtask
  task automatic cmd(input logic [2:0] c, input logic [63:0] pw, input logic ok);
    int k;
    mrpg_host_inst.send(c, pw);
    k = 0;
    while (CMD_DONE !== 1'b1 && k < 8) begin
      @(posedge CLK);
      #1;
      k++;
    end
    chk("command done", 48'h1, 48'(CMD_DONE));
    chk("command grant", 48'(ok), 48'(CMD_OK));
    @(negedge CLK);
  endtask
  task automatic pulse(input logic minute, input logic alarm, input int n);
    repeat (n) begin
      @(negedge CLK);
      MINUTE_TICK = minute;
      SAMPLE_TICK = !minute;
      ALARM_HIT = alarm;
      @(negedge CLK);
      MINUTE_TICK = 1'b0;
      SAMPLE_TICK = 1'b0;
      ALARM_HIT = 1'b0;
    end
    repeat (3) @(negedge CLK);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #1000000;
    failures++;
    tally_and_finish();
  end
  initial begin
    logic [47:0] v;
    void'($urandom(32'h1f43));
    rpw = {$urandom, $urandom};
    fpw = {$urandom, $urandom};
    d = 24'(2 + $urandom % 3);
    repeat (10) @(negedge CLK);
    NRST = 1'b1;
    rd(mrpg_pkg::OFS_PART, 1, v);
    chk("part code", 48'(mrpg_pkg::PART_CODE), v);
    rd(mrpg_pkg::OFS_PWCTL, 1, v);
    chk("gate control", 48'(mrpg_pkg::PWCTL_RESET), v);
    repeat (3) begin
      cmd(3'h5, fpw, 1'b1);
      lt++;
    end
    cmd(3'h1, rpw, gate(rpw, fpw, 1'b0));
    wr(mrpg_pkg::OFS_DELAY, 3, 136'(fpw[23:0]));
    rd(mrpg_pkg::OFS_DELAY, 3, v);
    chk("start delay", 48'(fpw[23:0]), v);
    wr(mrpg_pkg::OFS_DELAY, 3, 136'(d));
    wr(mrpg_pkg::OFS_PWCTL, 17, {fpw, rpw, mrpg_pkg::PW_ENABLE_PATTERN});
    close_commit();
    rd(mrpg_pkg::OFS_RPW, 6, v);
    chk("password bytes", 48'h0, v);
    rd(mrpg_pkg::OFS_LCOUNT, 3, v);
    chk("lifetime count", 48'(lt), v);
    cmd(3'h3, fpw ^ 64'h1, gate(fpw ^ 64'h1, fpw, 1'b1));
    cmd(3'h3, rpw, 1'b0);
    chk("mission flag", 48'h0, 48'(MISSION_ACTIVE));
    RTC_TIME = 48'h2512_3123_5958;
    cmd(3'h3, fpw, 1'b1);
    chk("mission flag", 48'h1, 48'(MISSION_ACTIVE));
    cmd(3'h1, fpw, 1'b1);
    wr(mrpg_pkg::OFS_DELAY, 1, 136'h00FF);
    wr(mrpg_pkg::OFS_PWCTL, 17, 136'h0);
    close_commit();
    rd(mrpg_pkg::OFS_DELAY, 3, v);
    chk("delay in mission", 48'(d), v);
    rd(mrpg_pkg::OFS_PWCTL, 1, v);
    chk("gate control", 48'(mrpg_pkg::PW_ENABLE_PATTERN), v);
    cmd(3'h5, rpw, 1'b0);
    pulse(1'b1, 1'b0, int'(d) - 1);
    rd(mrpg_pkg::OFS_MCOUNT, 3, v);
    chk("count in delay", 48'h0, v);
    pulse(1'b1, 1'b0, 1);
    rd(mrpg_pkg::OFS_STAMP, 6, v);
    chk("timestamp", RTC_TIME, v);
    pulse(1'b0, 1'b0, 1);
    lt = lt + 24'h2;
    rd(mrpg_pkg::OFS_MCOUNT, 3, v);
    chk("mission count", 48'h2, v);
    rd(mrpg_pkg::OFS_LCOUNT, 3, v);
    chk("lifetime count", 48'(lt), v);
    cmd(3'h2, fpw, 1'b0);
    cmd(3'h4, fpw, 1'b1);
    chk("mission flag", 48'h0, 48'(MISSION_ACTIVE));
    cmd(3'h2, fpw, 1'b1);
    rd(mrpg_pkg::OFS_MCOUNT, 3, v);
    chk("wiped count", 48'h0, v);
    cmd(3'h0, rpw, 1'b1);
    cmd(3'h0, ~rpw, 1'b0);
    START_ON_ALARM = 1'b1;
    cmd(3'h3, fpw, 1'b1);
    pulse(1'b0, 1'b1, 1);
    pulse(1'b1, 1'b0, int'(d));
    chk("waiting alarm", 48'h1, 48'(WAITING_ALARM));
    pulse(1'b0, 1'b0, 1);
    lt++;
    rd(mrpg_pkg::OFS_LCOUNT, 3, v);
    chk("alarm test count", 48'(lt), v);
    tally_and_finish();
  end
endmodule
